/* hdl/fdc_cfg_pkg.sv */
/*
  Constants and carrier types for the floppy configuration register bank.
  Assumes one 50 MHz clock and an 8-bit register port with one-cycle read data.
*/
package fdc_cfg_pkg;

  // register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [7:0] OFS_MODE = 8'hF0;
  localparam logic [7:0] OFS_TYPE = 8'hF2;
  localparam logic [7:0] OFS_STAT = 8'hF4;

  // mode register fields
  localparam int MODE_FWP_BIT = 0;
  localparam int MODE_DEN_LSB = 2;
  localparam int MODE_DEN_MSB = 3;
  localparam logic [7:0] MODE_WR_MASK = 8'h0D;
  localparam logic [7:0] MODE_RST = 8'h00;

  // drive type register fields
  localparam int TYPE_A_LSB = 0;
  localparam int TYPE_B_LSB = 2;
  localparam int TYPE_W = 2;
  localparam logic [7:0] TYPE_RST = 8'hFF;

  // status register fields
  localparam int STAT_WP_BIT = 1;
  localparam int STAT_DEN_BIT = 2;
  localparam int STAT_PP_WP_BIT = 3;
  localparam int STAT_BOOT_LSB = 4;

  // boot drive is fixed
  localparam logic [1:0] BOOT_DRIVE = 2'h0;

  // density override codes
  typedef enum logic [1:0] {
    FDC_DEN_NORMAL = 2'b00,
    FDC_DEN_USER = 2'b01,
    FDC_DEN_FORCE1 = 2'b10,
    FDC_DEN_FORCE0 = 2'b11
  } fdc_den_t;

  // drive-side pins, all active low
  typedef struct packed {
    logic drive_select0_n;
    logic drive_select1_n;
    logic write_protect_in_n;
  } fdc_drv_t;

  // register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } fdc_req_t;

endpackage : fdc_cfg_pkg

/* hdl/fdc_cfg_regs.sv */
/*
  Floppy configuration register bank: write-protect forming for the native
  and parallel-port controller paths, density override, drive type store.
  Assumes a synchronous 8-bit register port, read data one cycle after the
  read strobe, and a global protect bit supplied by a register elsewhere.
*/
// Functional notes
// [R01] protect when drive1 forced, pin, or global
// [R02] drive0 selected with forced also protects
// [R03] combined protect readable as status bit 1
// [R04] global protect bit comes from elsewhere
// [R05] boot drive is always drive 0
// [R06] forced protect also covers parallel-port path
// [R07] density code: 00/01 normal, 10 one, 11 zero
// [R08] mode bits 1 and 7:4 reserved, inert
// [R09] drive type register read/write, A and B
// [R10] type bits 5:4 stored only
// [R11] only two drives used, rest stored
// [R12] type register resets on standby and hard
// [R13] type register default is all ones
`timescale 1ns/1ps
module fdc_cfg_regs
  import fdc_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic hard_reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire fdc_drv_t drv_pins,
  input wire fdc_drv_t pp_drv_pins,
  input wire logic global_wp,
  input wire logic density_native,
  output logic write_protect_core_n,
  output logic write_protect_pp_n,
  output logic floppy_status_a_wp,
  output logic density_out,
  output logic [1:0] drive_a_type,
  output logic [1:0] drive_b_type,
  output logic [1:0] boot_drive
);

  // request bundle
  fdc_req_t req;

  // register state
  logic [DATA_W-1:0] mode_q;
  logic [DATA_W-1:0] mode_d;
  logic [DATA_W-1:0] type_q;
  logic [DATA_W-1:0] type_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic [1:0] boot_q;

  // decode
  logic hit_mode;
  logic hit_type;
  logic hit_stat;
  logic wr_mode;
  logic wr_type;

  // derived
  logic forced_wp;
  fdc_den_t den_mode;
  logic wp_core_q;
  logic wp_pp_q;
  logic [DATA_W-1:0] stat_view;

  always_comb begin
    req.addr = reg_addr;
    req.wdata = reg_wdata;
    req.wr = reg_wr;
    req.rd = reg_rd;
  end

  // address decode
  always_comb begin
    hit_mode = (req.addr == OFS_MODE);
    hit_type = (req.addr == OFS_TYPE);
    hit_stat = (req.addr == OFS_STAT);
    wr_mode = req.wr && hit_mode;
    wr_type = req.wr && hit_type;
  end

  // mode register: reserved bits never stored so they cannot act
  always_comb begin
    mode_d = mode_q;
    if (wr_mode) begin
      mode_d = req.wdata & MODE_WR_MASK; // see [R08]
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= MODE_RST;
    end else if (hard_reset) begin
      mode_q <= MODE_RST;
    end else begin
      mode_q <= mode_d;
    end
  end

  // drive type register: all eight bits kept and read back, only A and B leave as drive type outputs
  always_comb begin
    type_d = type_q;
    if (wr_type) begin
      type_d = req.wdata; // see [R09] [R10] [R11]
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      type_q <= TYPE_RST; // see [R12] [R13]
    end else if (hard_reset) begin
      type_q <= TYPE_RST; // see [R12] [R13]
    end else begin
      type_q <= type_d;
    end
  end

  // fields
  always_comb begin
    forced_wp = mode_q[MODE_FWP_BIT];
    den_mode = fdc_den_t'(mode_q[MODE_DEN_MSB:MODE_DEN_LSB]);
  end

  // native drive path
  fdc_wp_combine u_wp_core (
    .clk(clk),
    .resetn(resetn),
    .drv(drv_pins),
    .forced_wp(forced_wp),
    .global_wp(global_wp),
    .wp_q(wp_core_q)
  );

  // parallel-port drive path shares the same forced setting
  fdc_wp_combine u_wp_pp (
    .clk(clk),
    .resetn(resetn),
    .drv(pp_drv_pins),
    .forced_wp(forced_wp), // see [R06]
    .global_wp(global_wp),
    .wp_q(wp_pp_q)
  );

  fdc_density_sel u_density (
    .clk(clk),
    .resetn(resetn),
    .mode(den_mode),
    .density_native(density_native),
    .density_q(density_out)
  );

  // boot drive never moves; held in a flop so software sees it in status
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      boot_q <= BOOT_DRIVE;
    end else begin
      boot_q <= BOOT_DRIVE; // see [R05]
    end
  end

  // status view
  always_comb begin
    stat_view = '0;
    stat_view[STAT_WP_BIT] = wp_core_q; // see [R03]
    stat_view[STAT_DEN_BIT] = density_out;
    stat_view[STAT_PP_WP_BIT] = wp_pp_q;
    stat_view[STAT_BOOT_LSB +: 2] = boot_q;
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = '0;
    if (req.rd) begin
      if (hit_mode) begin
        rdata_d = mode_q;
      end else if (hit_type) begin
        rdata_d = type_q; // see [R09]
      end else if (hit_stat) begin
        rdata_d = stat_view;
      end else begin
        rdata_d = '0;
      end
    end
  end

  // data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // outputs
  always_comb begin
    reg_rdata = rdata_q;
    write_protect_core_n = !wp_core_q; // see [R01]
    write_protect_pp_n = !wp_pp_q; // see [R06]
    floppy_status_a_wp = wp_core_q; // see [R03]
    drive_a_type = type_q[TYPE_A_LSB +: TYPE_W]; // see [R11]
    drive_b_type = type_q[TYPE_B_LSB +: TYPE_W]; // see [R11]
    boot_drive = boot_q;
  end

endmodule : fdc_cfg_regs

/* hdl/fdc_density_sel.sv */
/*
  Density select override decoder.
  Assumes the native density level comes from the controller core; output registered.
*/
`timescale 1ns/1ps
module fdc_density_sel
  import fdc_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire fdc_den_t mode,
  input wire logic density_native,
  output logic density_q
);

  logic density_d;

  always_comb begin
    case (mode)
      FDC_DEN_NORMAL: density_d = density_native; // see [R07]
      FDC_DEN_USER: density_d = density_native; // see [R07]
      FDC_DEN_FORCE1: density_d = 1'b1; // see [R07]
      FDC_DEN_FORCE0: density_d = 1'b0; // see [R07]
      default: density_d = density_native;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      density_q <= 1'b0;
    end else begin
      density_q <= density_d;
    end
  end

endmodule : fdc_density_sel

/* hdl/fdc_wp_combine.sv */
/*
  Write-protect combiner for one drive path.
  Assumes drive-side inputs synchronous to clk; output is registered.
*/
`timescale 1ns/1ps
module fdc_wp_combine
  import fdc_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire fdc_drv_t drv,
  input wire logic forced_wp,
  input wire logic global_wp,
  output logic wp_q
);

  logic wp_d;

  // any selected drive under forced protect, the drive's own tab, or global
  always_comb begin
    wp_d = (!drv.drive_select0_n && forced_wp) // see [R02]
      || (!drv.drive_select1_n && forced_wp) // see [R01]
      || !drv.write_protect_in_n // see [R01]
      || global_wp; // see [R04]
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
    end
  end

endmodule : fdc_wp_combine

/* verif/fdc_cfg_regs_assertions.sv */
/* port checker for fdc_cfg_regs.
   assumes one clock and async active-low resetn. */
`timescale 1ns/1ps
module fdc_cfg_regs_assertions
  import fdc_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic hard_reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire fdc_drv_t drv_pins,
  input wire fdc_drv_t pp_drv_pins,
  input wire logic global_wp,
  input wire logic density_native,
  input wire logic write_protect_core_n,
  input wire logic write_protect_pp_n,
  input wire logic floppy_status_a_wp,
  input wire logic density_out,
  input wire logic [1:0] drive_a_type,
  input wire logic [1:0] drive_b_type,
  input wire logic [1:0] boot_drive
);
  logic [2:0] mode_q;
  logic wp_c;
  logic pp_c;
  logic den_c;
  // shadow of forced bit and density code
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) mode_q <= 3'h0;
    else if (hard_reset) mode_q <= 3'h0;
    else if (reg_wr && reg_addr == OFS_MODE) mode_q <= {reg_wdata[3:2], reg_wdata[0]};
  end
  assign wp_c = (mode_q[0] & !(drv_pins.drive_select0_n & drv_pins.drive_select1_n))
    | !drv_pins.write_protect_in_n | global_wp;
  assign pp_c = (mode_q[0] & !(pp_drv_pins.drive_select0_n & pp_drv_pins.drive_select1_n))
    | !pp_drv_pins.write_protect_in_n | global_wp;
  assign den_c = mode_q[2] ? !mode_q[1] : density_native;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_wp_core: assert property ($past(resetn) |-> write_protect_core_n == !$past(wp_c))
    else $error("core protect wrong");
  chk_wp_status: assert property ($past(resetn) |-> floppy_status_a_wp == $past(wp_c))
    else $error("status protect differs");
  chk_wp_pp: assert property ($past(resetn) |-> write_protect_pp_n == !$past(pp_c))
    else $error("pp protect wrong");
  chk_den_map: assert property ($past(resetn) |-> density_out == $past(den_c))
    else $error("density wrong");
  chk_boot_fixed: assert property (boot_drive == BOOT_DRIVE)
    else $error("boot drive moved");
  chk_type_write: assert property (reg_wr && reg_addr == OFS_TYPE && !hard_reset
    |=> {drive_b_type, drive_a_type} == $past(reg_wdata[3:0])) else $error("type write lost");
  chk_type_dflt: assert property (hard_reset |=> {drive_b_type, drive_a_type} == 4'hF)
    else $error("type default wrong");
  chk_type_read: assert property (reg_rd && reg_addr == OFS_TYPE
    |=> reg_rdata[3:0] == {$past(drive_b_type), $past(drive_a_type)}) else $error("type read");
  chk_mode_rsvd: assert property (reg_rd && reg_addr == OFS_MODE |=> (reg_rdata & 8'hF2) == 8'h00)
    else $error("reserved mode bits read");
  cover property (hard_reset);
  cover property (!write_protect_core_n && global_wp == 1'b0);
  cover property (reg_rd && reg_addr == OFS_TYPE);
endmodule : fdc_cfg_regs_assertions
bind fdc_cfg_regs fdc_cfg_regs_assertions i_fdc_cfg_regs_assertions (.*);

/* verif/fdc_drive_model.sv */
/* two floppy drives with protect tabs.
   assumes active-low selects, pulled-up shared protect line. */
`timescale 1ns/1ps
module fdc_drive_model (
  input wire logic [1:0] sel_n,
  input wire logic [1:0] tab,
  output logic wp_n
);
  // open collector: pull-up holds it high when no tabbed drive is selected
  assign wp_n = !(|(~sel_n & tab));
endmodule : fdc_drive_model

/* verif/tb_top.sv */
/* self-checking bench for fdc_cfg_regs.
   assumes the drive model and the bound checker. */
`timescale 1ns/1ps
module tb_top
  import fdc_cfg_pkg::*;
;
  logic clk, resetn, hard_reset, reg_wr, reg_rd, global_wp, density_native;
  logic rd_d, wpc_n, wpp_n, sta, den, wp_n, e, ep;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] sel_n, tab, ta, tb, bd;
  logic [15:0] lfsr;
  logic [7:0] exp_q[$];
  int n_mismatch, total_checks, cyc, i;
  fdc_drv_t drv, pp;
  assign drv = {sel_n[0], sel_n[1], wp_n};
  assign pp = {sel_n[0], sel_n[1], 1'b1};
  fdc_drive_model i_fdc_drive_model (.sel_n(sel_n), .tab(tab), .wp_n(wp_n));
  fdc_cfg_regs i_fdc_cfg_regs (.clk(clk), .resetn(resetn), .hard_reset(hard_reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .drv_pins(drv), .pp_drv_pins(pp), .global_wp(global_wp),
    .density_native(density_native), .write_protect_core_n(wpc_n),
    .write_protect_pp_n(wpp_n), .floppy_status_a_wp(sta), .density_out(den),
    .drive_a_type(ta), .drive_b_type(tb), .boot_drive(bd));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(x);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd
  // read data stands only one cycle, so look at it mid-cycle
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) if (rd_d) check(reg_rdata, exp_q.pop_front());
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    {resetn, hard_reset, reg_wr, reg_rd, global_wp, density_native} = 6'h00;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    sel_n = 2'h3;
    tab = 2'h0;
    lfsr = 16'hD31D;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    check({2'h0, wpc_n, wpp_n, sta, den, bd}, 8'h30);
    check({4'h0, tb, ta}, {4'h0, TYPE_RST[3:0]});
    rd(OFS_TYPE, 8'hFF);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      wr(OFS_TYPE, lfsr[7:0]);
      rd(OFS_TYPE, lfsr[7:0]);
      check({tb, ta}, lfsr[3:0]);
    end
    rd(8'h37, 8'h00);
    wr(OFS_MODE, 8'hFF);
    rd(OFS_MODE, MODE_WR_MASK);
    $display("test registers done");
    for (i = 0; i < 8; i++) begin
      wr(OFS_MODE, {4'h0, i[1:0], 2'h0});
      density_native <= i[2];
      repeat (2) @(posedge clk);
      @(negedge clk);
      check(den, i[1] ? !i[0] : i[2]);
    end
    $display("test density done");
    for (i = 0; i < 32; i++) begin
      wr(OFS_MODE, {7'h0, i[0]});
      sel_n <= i[2:1];
      tab <= {2{i[3]}};
      global_wp <= i[4];
      repeat (2) @(posedge clk);
      @(negedge clk);
      ep = (i[0] & (i[2:1] != 2'h3)) | i[4];
      e = ep | (i[3] & (i[2:1] != 2'h3));
      check({wpc_n, wpp_n, sta, bd}, {!e, !ep, e, 2'h0});
      // density override idle here, so status bit 2 follows the native level
      rd(OFS_STAT, {4'h0, ep, density_native, e, 1'b0});
    end
    $display("test protect done");
    wr(OFS_TYPE, 8'h00);
    @(posedge clk);
    hard_reset <= 1'b1;
    @(posedge clk);
    hard_reset <= 1'b0;
    rd(OFS_TYPE, 8'hFF);
    rd(OFS_MODE, 8'h00);
    // standby reset in mid-run must reload the type default as well
    wr(OFS_TYPE, 8'h5A);
    @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    rd(OFS_TYPE, 8'hFF);
    repeat (3) @(posedge clk);
    $display("test hard reset done");
    close_out();
  end
endmodule : tb_top
